// >>> hw/line_event_latch.sv
// Purpose: Two-channel event latches with read-to-clear and an error counter readout.
// Assumes: Live status and error pulses arrive from pins and are synchronised here.
// Notes:   One interrupt output, high while any latched bit of either channel is set.
//
// Function
// - Reading event register returns bits, then clears
// - First event register at 18H and 38H
// - Second event register at 19H and 39H
// - Bit 6 first: inband activate event
// - Bit 5 first: inband deactivate event
// - Bit 4 first: pattern sync event
// - Bit 3 first: transmit clock loss event
// - Bit 2 first: driver fault event
// - Bit 1 first: alarm indication event
// - Bit 0 first: loss of signal event
// - Bit 7 second: amplitude overflow event
// - Bit 6 second: jitter buffer overflow
// - Bit 5 second: jitter buffer underflow
// - Bit 4 second: pattern error event
// - Bit 3 second: excess zeros event
// - Bit 2 second: code violation event
// - Bit 1 second: one-second timer expiry
// - Bit 0 second: counter overflow event
// - Low byte shows counter bits 7..0
// - High byte at 1BH/3BH shows bits 15..8
// - Unmasked rising edge, or any edge, raises event
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "line_event_map.svh"

module line_event_latch #(
	parameter int CHANNELS = 2
) (
	input  wire logic                       clk_sys,
	input  wire logic                       srst,
	input  wire line_event_pkg::addr_t      reg_addr,
	input  wire line_event_pkg::byte_t      reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output line_event_pkg::byte_t           reg_rdata,
	input  wire logic [CHANNELS*8-1:0]      status_a_in,
	input  wire logic [CHANNELS*8-1:0]      status_b_in,
	input  wire logic [CHANNELS-1:0]        error_pulse_in,
	output logic                            irq
);
	import line_event_pkg::*;

	initial begin
		if (CHANNELS != 2) begin
			$error("line_event_latch serves exactly two channels");
		end
		if (`ADDR_W != $bits(addr_t)) begin
			$error("address map and address type disagree in width");
		end
	end

	// ****************************************
	// Input synchronisers
	// ****************************************
	// Status lines come from detectors outside this clock; two flops before use.
	logic [CHANNELS*8-1:0] sync1_a_ff;
	logic [CHANNELS*8-1:0] sync2_a_ff;
	logic [CHANNELS*8-1:0] prev_a_ff;
	logic [CHANNELS*8-1:0] sync1_b_ff;
	logic [CHANNELS*8-1:0] sync2_b_ff;
	logic [CHANNELS*8-1:0] prev_b_ff;
	logic [CHANNELS-1:0]   sync1_err_ff;
	logic [CHANNELS-1:0]   sync2_err_ff;
	logic [CHANNELS-1:0]   prev_err_ff;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sync1_a_ff   <= '0;
			sync2_a_ff   <= '0;
			prev_a_ff    <= '0;
			sync1_b_ff   <= '0;
			sync2_b_ff   <= '0;
			prev_b_ff    <= '0;
			sync1_err_ff <= '0;
			sync2_err_ff <= '0;
			prev_err_ff  <= '0;
		end else begin
			sync1_a_ff   <= status_a_in;
			sync2_a_ff   <= sync1_a_ff;
			prev_a_ff    <= sync2_a_ff;
			sync1_b_ff   <= status_b_in;
			sync2_b_ff   <= sync1_b_ff;
			prev_b_ff    <= sync2_b_ff;
			sync1_err_ff <= error_pulse_in;
			sync2_err_ff <= sync1_err_ff;
			prev_err_ff  <= sync2_err_ff;
		end
	end

	// ****************************************
	// Registers and decode
	// ****************************************
	byte_t       evt_a_ff    [CHANNELS];
	byte_t       evt_b_ff    [CHANNELS];
	byte_t       mask_a_ff   [CHANNELS];
	byte_t       mask_b_ff   [CHANNELS];
	byte_t       edge_a_ff   [CHANNELS];
	byte_t       edge_b_ff   [CHANNELS];
	logic [15:0] count_ff    [CHANNELS];
	byte_t       nxt_evt_a   [CHANNELS];
	byte_t       nxt_evt_b   [CHANNELS];
	byte_t       raise_a     [CHANNELS];
	byte_t       raise_b     [CHANNELS];
	logic        cnt_wrap    [CHANNELS];
	byte_t       rdata_ff;
	byte_t       nxt_rdata;

	function automatic addr_t ch_addr(input addr_t base, input int ch);
		ch_addr = (ch == 0) ? base : (base | 6'h20);
	endfunction

	// Unmasked events: rising edge when edge select is 0, any change when 1.
	function automatic byte_t raise(input byte_t now, input byte_t was,
		input byte_t mask, input byte_t edge_sel);
		raise = ~mask & ((now & ~was) | (edge_sel & ~now & was));
	endfunction

	// ****************************************
	// Error counter and event latches
	// ****************************************
	// The counter saturates its own overflow into an event but wraps its value.
	always_ff @(posedge clk_sys) begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (srst) begin
				count_ff[c] <= `CNT_RESET;
			end else if (sync2_err_ff[c] && !prev_err_ff[c]) begin
				count_ff[c] <= count_ff[c] + 16'h0001;
			end
		end
	end

	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			cnt_wrap[c] = sync2_err_ff[c] && !prev_err_ff[c] && (count_ff[c] == 16'hffff);
			raise_a[c]  = raise(sync2_a_ff[c*8 +: 8], prev_a_ff[c*8 +: 8],
				mask_a_ff[c], edge_a_ff[c]) & `EVT_A_USED;
			raise_b[c]  = raise(sync2_b_ff[c*8 +: 8], prev_b_ff[c*8 +: 8],
				mask_b_ff[c], edge_b_ff[c]);
			raise_b[c][`BIT_CNT_OVER] = raise_b[c][`BIT_CNT_OVER]
				| (cnt_wrap[c] & ~mask_b_ff[c][`BIT_CNT_OVER]);
			nxt_evt_a[c] = evt_a_ff[c];
			nxt_evt_b[c] = evt_b_ff[c];
			if (reg_rd && reg_addr == ch_addr(`EVT_A_CH0_OFF, c)) begin
				nxt_evt_a[c] = `EVT_RESET;
			end
			if (reg_rd && reg_addr == ch_addr(`EVT_B_CH0_OFF, c)) begin
				nxt_evt_b[c] = `EVT_RESET;
			end
			nxt_evt_a[c] = nxt_evt_a[c] | raise_a[c];
			nxt_evt_b[c] = nxt_evt_b[c] | raise_b[c];
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (srst) begin
				evt_a_ff[c] <= `EVT_RESET;
				evt_b_ff[c] <= `EVT_RESET;
			end else begin
				evt_a_ff[c] <= nxt_evt_a[c];
				evt_b_ff[c] <= nxt_evt_b[c];
			end
		end
	end

	// ****************************************
	// Named event fields
	// ****************************************
	// Each latched bit is named, so the readback is built field by field from the map.
	logic [CHANNELS-1:0] inband_activate_event;
	logic [CHANNELS-1:0] inband_deactivate_event;
	logic [CHANNELS-1:0] pattern_sync_event;
	logic [CHANNELS-1:0] tx_clock_loss_event;
	logic [CHANNELS-1:0] driver_fault_event;
	logic [CHANNELS-1:0] alarm_indication_event;
	logic [CHANNELS-1:0] signal_loss_event;
	logic [CHANNELS-1:0] amplitude_overflow_event;
	logic [CHANNELS-1:0] jitter_buffer_over_event;
	logic [CHANNELS-1:0] jitter_buffer_under_event;
	logic [CHANNELS-1:0] pattern_error_event;
	logic [CHANNELS-1:0] excess_zeros_event;
	logic [CHANNELS-1:0] code_violation_event;
	logic [CHANNELS-1:0] second_tick_event;
	logic [CHANNELS-1:0] counter_overflow_event;
	byte_t               error_count_low_bits  [CHANNELS];
	byte_t               error_count_high_bits [CHANNELS];
	byte_t               event_latch_a         [CHANNELS];
	byte_t               event_latch_b         [CHANNELS];

	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			inband_activate_event[c]     = evt_a_ff[c][`BIT_INBAND_ACT];
			inband_deactivate_event[c]   = evt_a_ff[c][`BIT_INBAND_DEACT];
			pattern_sync_event[c]        = evt_a_ff[c][`BIT_PATTERN_SYNC];
			tx_clock_loss_event[c]       = evt_a_ff[c][`BIT_TX_CLK_LOSS];
			driver_fault_event[c]        = evt_a_ff[c][`BIT_DRIVER_FAULT];
			alarm_indication_event[c]    = evt_a_ff[c][`BIT_ALARM_IND];
			signal_loss_event[c]         = evt_a_ff[c][`BIT_SIGNAL_LOSS];
			amplitude_overflow_event[c]  = evt_b_ff[c][`BIT_AMP_OVER];
			jitter_buffer_over_event[c]  = evt_b_ff[c][`BIT_JIT_OVER];
			jitter_buffer_under_event[c] = evt_b_ff[c][`BIT_JIT_UNDER];
			pattern_error_event[c]       = evt_b_ff[c][`BIT_PATTERN_ERR];
			excess_zeros_event[c]        = evt_b_ff[c][`BIT_EXCESS_ZEROS];
			code_violation_event[c]      = evt_b_ff[c][`BIT_CODE_VIOL];
			second_tick_event[c]         = evt_b_ff[c][`BIT_SECOND_TICK];
			counter_overflow_event[c]    = evt_b_ff[c][`BIT_CNT_OVER];
			error_count_low_bits[c]      = count_ff[c][7:0];
			error_count_high_bits[c]     = count_ff[c][15:8];
		end
	end

	// Bit 7 of the first register has no event behind it and always reads 0.
	function automatic byte_t pack_a(
		input logic act,
		input logic deact,
		input logic sync,
		input logic clk_loss,
		input logic fault,
		input logic alarm,
		input logic loss
	);
		pack_a                    = `EVT_RESET;
		pack_a[`BIT_INBAND_ACT]   = act;
		pack_a[`BIT_INBAND_DEACT] = deact;
		pack_a[`BIT_PATTERN_SYNC] = sync;
		pack_a[`BIT_TX_CLK_LOSS]  = clk_loss;
		pack_a[`BIT_DRIVER_FAULT] = fault;
		pack_a[`BIT_ALARM_IND]    = alarm;
		pack_a[`BIT_SIGNAL_LOSS]  = loss;
	endfunction

	function automatic byte_t pack_b(
		input logic amp,
		input logic jit_over,
		input logic jit_under,
		input logic pat_err,
		input logic zeros,
		input logic viol,
		input logic tick,
		input logic cnt_over
	);
		pack_b                    = `EVT_RESET;
		pack_b[`BIT_AMP_OVER]     = amp;
		pack_b[`BIT_JIT_OVER]     = jit_over;
		pack_b[`BIT_JIT_UNDER]    = jit_under;
		pack_b[`BIT_PATTERN_ERR]  = pat_err;
		pack_b[`BIT_EXCESS_ZEROS] = zeros;
		pack_b[`BIT_CODE_VIOL]    = viol;
		pack_b[`BIT_SECOND_TICK]  = tick;
		pack_b[`BIT_CNT_OVER]     = cnt_over;
	endfunction

	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			event_latch_a[c] = pack_a(
				inband_activate_event[c],
				inband_deactivate_event[c],
				pattern_sync_event[c],
				tx_clock_loss_event[c],
				driver_fault_event[c],
				alarm_indication_event[c],
				signal_loss_event[c]);
			event_latch_b[c] = pack_b(
				amplitude_overflow_event[c],
				jitter_buffer_over_event[c],
				jitter_buffer_under_event[c],
				pattern_error_event[c],
				excess_zeros_event[c],
				code_violation_event[c],
				second_tick_event[c],
				counter_overflow_event[c]);
		end
	end

	// ****************************************
	// Mask and edge select writes
	// ****************************************
	always_ff @(posedge clk_sys) begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (srst) begin
				mask_a_ff[c] <= `MASK_RESET;
				mask_b_ff[c] <= `MASK_RESET;
				edge_a_ff[c] <= `EDGE_RESET;
				edge_b_ff[c] <= `EDGE_RESET;
			end else if (reg_wr) begin
				if (reg_addr == ch_addr(`MASK_A_CH0_OFF, c)) begin
					mask_a_ff[c] <= reg_wdata;
				end
				if (reg_addr == ch_addr(`MASK_B_CH0_OFF, c)) begin
					mask_b_ff[c] <= reg_wdata;
				end
				if (reg_addr == ch_addr(`EDGE_A_CH0_OFF, c)) begin
					edge_a_ff[c] <= reg_wdata;
				end
				if (reg_addr == ch_addr(`EDGE_B_CH0_OFF, c)) begin
					edge_b_ff[c] <= reg_wdata;
				end
			end
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Data is captured from the pre-clear value so the read sees what it clears.
	always_comb begin
		nxt_rdata = `READ_DATA_IDLE;
		for (int c = 0; c < CHANNELS; c++) begin
			if (reg_addr == ch_addr(`EVT_A_CH0_OFF, c)) begin
				nxt_rdata = event_latch_a[c];
			end
			if (reg_addr == ch_addr(`EVT_B_CH0_OFF, c)) begin
				nxt_rdata = event_latch_b[c];
			end
			if (reg_addr == ch_addr(`CNT_LO_CH0_OFF, c)) begin
				nxt_rdata = error_count_low_bits[c];
			end
			if (reg_addr == ch_addr(`CNT_HI_CH0_OFF, c)) begin
				nxt_rdata = error_count_high_bits[c];
			end
			if (reg_addr == ch_addr(`MASK_A_CH0_OFF, c)) begin
				nxt_rdata = mask_a_ff[c];
			end
			if (reg_addr == ch_addr(`MASK_B_CH0_OFF, c)) begin
				nxt_rdata = mask_b_ff[c];
			end
			if (reg_addr == ch_addr(`EDGE_A_CH0_OFF, c)) begin
				nxt_rdata = edge_a_ff[c];
			end
			if (reg_addr == ch_addr(`EDGE_B_CH0_OFF, c)) begin
				nxt_rdata = edge_b_ff[c];
			end
		end
		if (!reg_rd) begin
			nxt_rdata = `READ_DATA_IDLE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdata_ff <= `READ_DATA_IDLE;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

	// ****************************************
	// Interrupt request
	// ****************************************
	logic irq_ff;
	logic nxt_pending;

	// Built from the next latch value so the request moves on the same edge as the bits.
	always_comb begin
		nxt_pending = 1'b0;
		for (int c = 0; c < CHANNELS; c++) begin
			nxt_pending = nxt_pending | (|nxt_evt_a[c]) | (|nxt_evt_b[c]);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_pending;
		end
	end

	assign irq = irq_ff;

endmodule

// >>> hw/line_event_map.svh
// Purpose: Offsets, field positions and reset values for the event latch block.
// Assumes: Byte registers on a plain address/strobe port, one channel block every 0x20.
// Notes:   Definitions only.
`ifndef LINE_EVENT_MAP_SVH
`define LINE_EVENT_MAP_SVH

`define ADDR_W              6
`define EVT_A_CH0_OFF       6'h18
`define EVT_B_CH0_OFF       6'h19
`define CNT_LO_CH0_OFF      6'h1a
`define CNT_HI_CH0_OFF      6'h1b
`define EVT_A_CH1_OFF       6'h38
`define EVT_B_CH1_OFF       6'h39
`define CNT_LO_CH1_OFF      6'h3a
`define CNT_HI_CH1_OFF      6'h3b
`define MASK_A_CH0_OFF      6'h10
`define MASK_B_CH0_OFF      6'h11
`define EDGE_A_CH0_OFF      6'h12
`define EDGE_B_CH0_OFF      6'h13
`define MASK_A_CH1_OFF      6'h30
`define MASK_B_CH1_OFF      6'h31
`define EDGE_A_CH1_OFF      6'h32
`define EDGE_B_CH1_OFF      6'h33
`define EVT_RESET           8'h00
`define MASK_RESET          8'hff
`define EDGE_RESET          8'h00
`define CNT_RESET           16'h0000
`define EVT_A_USED          8'h7f
`define BIT_INBAND_ACT      6
`define BIT_INBAND_DEACT    5
`define BIT_PATTERN_SYNC    4
`define BIT_TX_CLK_LOSS     3
`define BIT_DRIVER_FAULT    2
`define BIT_ALARM_IND       1
`define BIT_SIGNAL_LOSS     0
`define BIT_AMP_OVER        7
`define BIT_JIT_OVER        6
`define BIT_JIT_UNDER       5
`define BIT_PATTERN_ERR     4
`define BIT_EXCESS_ZEROS    3
`define BIT_CODE_VIOL       2
`define BIT_SECOND_TICK     1
`define BIT_CNT_OVER        0
`define READ_DATA_IDLE      8'h00

`endif

// >>> hw/line_event_pkg.sv
// Purpose: Types shared by the event latch block.
// Assumes: Nothing beyond the map header.
// Notes:   Constants live in line_event_map.svh.
package line_event_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [5:0] addr_t;
endpackage

// >>> tb/line_event_checker.sv
// Purpose: Port-level assertions for the event latch block.
// Assumes: Event bits land three edges after an input moves.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ps
module line_event_checker #(
	parameter int CHANNELS = 2
) (
	input wire logic                  clk_sys,
	input wire logic                  srst,
	input wire line_event_pkg::addr_t reg_addr,
	input wire line_event_pkg::byte_t reg_wdata,
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire line_event_pkg::byte_t reg_rdata,
	input wire logic [CHANNELS*8-1:0] status_a_in,
	input wire logic [CHANNELS*8-1:0] status_b_in,
	input wire logic [CHANNELS-1:0]   error_pulse_in,
	input wire logic                  irq
);
	import line_event_pkg::*;
	// Cycles since an event input last moved, so checks skip windows with edges in flight.
	logic [3:0] quiet_ff;
	always_ff @(posedge clk_sys) begin
		if (srst || {status_a_in, status_b_in, error_pulse_in}
			!= $past({status_a_in, status_b_in, error_pulse_in}))
			quiet_ff <= 4'h0;
		else if (quiet_ff != 4'hf)
			quiet_ff <= quiet_ff + 4'h1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	idle_rdata_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	reset_quiet_a: assert property ($fell(srst) |-> !irq && reg_rdata == 8'h00)
		else $error("outputs not quiet after reset");
	bit7_zero_a: assert property (reg_rd && reg_addr[4:0] == 5'h18 |=> !reg_rdata[7])
		else $error("reserved bit set");
	unmapped_a: assert property (reg_rd && reg_addr[4:2] != 3'b110 && reg_addr[4:2] != 3'b100
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	read_clear_a: assert property (quiet_ff >= 4'h6 && reg_rd && reg_addr[4:1] == 4'hc ##2
		reg_rd && reg_addr == $past(reg_addr, 2) |=> reg_rdata == 8'h00)
		else $error("event register not cleared by read");
	irq_cause_a: assert property ($rose(irq) |-> quiet_ff <= 4'h5)
		else $error("interrupt without input change");
	irq_drop_a: assert property (reg_rd && reg_addr == 6'h18 ##2 reg_rd && reg_addr == 6'h19 ##2
		reg_rd && reg_addr == 6'h38 ##2 reg_rd && reg_addr == 6'h39 && quiet_ff >= 4'hc |=> !irq)
		else $error("interrupt stays after all reads");
	cnt_live_a: assert property (quiet_ff >= 4'h8 && reg_rd && reg_addr == 6'h1a ##2
		reg_rd && reg_addr == 6'h1a |=> reg_rdata == $past(reg_rdata, 2))
		else $error("counter moved without errors");
endmodule

// >>> tb/line_event_latch_test.sv
// Purpose: Directed test of event latches, read clear, interrupt and counter.
// Assumes: Register bus reads answer one cycle after the strobe.
// Notes:   Counter overflow is out of reach in run time.
`timescale 1ns/1ps
module line_event_latch_test;
	import line_event_pkg::*;
	logic        clk_sys, srst, reg_wr, reg_rd, irq;
	addr_t       reg_addr;
	byte_t       reg_wdata, reg_rdata, got, acc;
	logic [15:0] status_a_in, status_b_in;
	logic [1:0]  error_pulse_in;
	int          failures, n_compared;
	line_event_latch #(.CHANNELS(2)) i_dut (.clk_sys(clk_sys), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .status_a_in(status_a_in), .status_b_in(status_b_in),
		.error_pulse_in(error_pulse_in), .irq(irq));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input addr_t a, input byte_t d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input addr_t a, output byte_t d);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic chk(input byte_t seen, input byte_t exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rc(input addr_t a, input byte_t e);
		rd(a, got);
		chk(got, e);
	endtask
	task automatic complete_run;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// A hang in any wait ends the run here as a failure.
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		complete_run;
	end
	initial begin
		{srst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 6'h00, 8'h00};
		{status_a_in, status_b_in, error_pulse_in} = '0;
		{failures, n_compared} = '0;
		idle(16);
		srst <= 1'b0;
		rc(6'h18, 8'h00);
		rc(6'h39, 8'h00);
		rc(6'h1a, 8'h00);
		rc(6'h3b, 8'h00);
		rc(6'h00, 8'h00);
		rc(6'h27, 8'h00);
		for (int i = 0; i < 4; i++)
			wr({i[1], 4'b1000, i[0]}, 8'h00);
		status_a_in <= 16'h007f;
		status_b_in <= 16'h00ff;
		idle(8);
		chk({7'h0, irq}, 8'h01);
		idle(8);
		rc(6'h18, 8'h7f);
		rc(6'h19, 8'hff);
		rc(6'h38, 8'h00);
		rc(6'h39, 8'h00);
		chk({7'h0, irq}, 8'h00);
		// Walk one bit at a time through the second channel; falling bits must stay silent.
		for (int i = 0; i < 8; i++) begin
			status_a_in <= 16'h0100 << i;
			status_b_in <= 16'h0100 << i;
			idle(8);
			rc(6'h38, 8'h7f & (8'h01 << i));
			rc(6'h39, 8'h01 << i);
			rc(6'h38, 8'h00);
		end
		wr(6'h32, 8'h01);
		status_a_in <= 16'h0100;
		idle(8);
		rc(6'h38, 8'h01);
		status_a_in <= 16'h0000;
		idle(8);
		rc(6'h38, 8'h01);
		status_b_in <= 16'h0000;
		idle(8);
		rc(6'h39, 8'h00);
		wr(6'h30, 8'h01);
		status_a_in <= 16'h0100;
		idle(8);
		rc(6'h38, 8'h00);
		acc = 8'h00;
		status_a_in <= 16'h0004;
		// One idle edge puts the first read's strobe on the edge where the event lands.
		idle(1);
		repeat (6) begin
			rd(6'h18, got);
			acc = acc | got;
		end
		chk(acc, 8'h04);
		wr(6'h13, 8'h08);
		rc(6'h13, 8'h08);
		status_b_in <= 16'h0008;
		idle(8);
		rc(6'h19, 8'h08);
		status_b_in <= 16'h0000;
		idle(8);
		rc(6'h19, 8'h08);
		repeat (258) begin
			error_pulse_in <= 2'b01;
			idle(2);
			error_pulse_in <= 2'b00;
			idle(2);
		end
		idle(10);
		rc(6'h1a, 8'h02);
		rc(6'h1a, 8'h02);
		rc(6'h1b, 8'h01);
		rc(6'h3b, 8'h00);
		complete_run;
	end
endmodule
bind line_event_latch line_event_checker #(.CHANNELS(CHANNELS)) i_chk (.clk_sys(clk_sys),
	.srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_a_in(status_a_in),
	.status_b_in(status_b_in), .error_pulse_in(error_pulse_in), .irq(irq));
